// file: logic/ifd_alu.sv
/*
 Combinational decode and execute of one instruction word.
 Assumes operands are already read and special reads already applied.
*/
`timescale 1ns/10ps
`default_nettype none
module ifd_alu
   import ifd_pkg::*;
(
   input  wire logic [13:0] insn,
   input  wire logic [7:0]  w_in,
   input  wire logic [7:0]  f_in,
   input  wire logic        c_in,
   output logic      [7:0]  res,
   output logic             to_f,
   output logic             wr_w,
   output logic             z_upd,
   output logic             c_upd,
   output logic             dc_upd,
   output logic             z_o,
   output logic             c_o,
   output logic             dc_o,
   output logic             skip,
   output logic             jump,
   output logic      [10:0] k11,
   output logic      [6:0]  faddr
);
   logic [7:0] k8;
   logic [2:0] bsel;
   logic       dbit;
   logic [8:0] sum;
   logic [4:0] hsum;
   logic [7:0] mask;
   always_comb begin
      faddr = insn[F_LSB +: FW];
      dbit = insn[D_POS];
      bsel = insn[B_LSB +: 3];
      k8 = insn[K8_LSB +: 8];
      k11 = insn[K11_LSB +: 11];
      mask = 8'h01 << bsel;
      res = 8'h00; to_f = 1'b0; wr_w = 1'b0;
      z_upd = 1'b0; c_upd = 1'b0; dc_upd = 1'b0;
      c_o = c_in; dc_o = 1'b0;
      skip = 1'b0; jump = 1'b0;
      sum = 9'h000; hsum = 5'h00;
      case (insn[13:12])
         2'b00: begin
            to_f = dbit;
            wr_w = ~dbit;
            case (insn[11:8])
               4'h0: begin
                  to_f = dbit;                 // Move W to f, or nop forms
                  wr_w = 1'b0;
                  res = w_in;
               end
               4'h1: begin
                  res = 8'h00; z_upd = 1'b1;
               end
               4'h2: begin
                  sum = {1'b0, f_in} + {1'b0, ~w_in} + 9'h001;
                  hsum = {1'b0, f_in[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01;
                  res = sum[7:0]; z_upd = 1'b1; c_upd = 1'b1; dc_upd = 1'b1;
               end
               4'h3: begin res = f_in - 8'h01; z_upd = 1'b1; end
               4'h4: begin res = f_in | w_in; z_upd = 1'b1; end
               4'h5: begin res = f_in & w_in; z_upd = 1'b1; end
               4'h6: begin res = f_in ^ w_in; z_upd = 1'b1; end
               4'h7: begin
                  sum = {1'b0, f_in} + {1'b0, w_in};
                  hsum = {1'b0, f_in[3:0]} + {1'b0, w_in[3:0]};
                  res = sum[7:0]; z_upd = 1'b1; c_upd = 1'b1; dc_upd = 1'b1;
               end
               4'h8: begin res = f_in; z_upd = 1'b1; end
               4'h9: begin res = ~f_in; z_upd = 1'b1; end
               4'hA: begin res = f_in + 8'h01; z_upd = 1'b1; end
               4'hB: begin res = f_in - 8'h01; skip = (res == 8'h00); end
               4'hC: begin res = {c_in, f_in[7:1]}; c_upd = 1'b1; sum[8] = f_in[0]; end
               4'hD: begin res = {f_in[6:0], c_in}; c_upd = 1'b1; sum[8] = f_in[7]; end
               4'hE: res = {f_in[3:0], f_in[7:4]};
               default: begin res = f_in + 8'h01; skip = (res == 8'h00); end
            endcase
            if (insn[11:8] == 4'h1 && !dbit) begin
               to_f = 1'b0; wr_w = 1'b1;       // Clear W form
            end
            if (insn[11:8] == 4'h0 && !dbit) begin
               to_f = 1'b0; wr_w = 1'b0;       // Control forms run as no-op
               jump = (insn[7:1] == 7'b0000100); // Return forms
            end
            c_o = sum[8];
            dc_o = hsum[4];
         end
         2'b01: begin
            case (insn[11:10])
               2'b00: begin res = f_in & ~mask; to_f = 1'b1; end
               2'b01: begin res = f_in | mask; to_f = 1'b1; end
               2'b10: skip = ((f_in & mask) == 8'h00);
               default: skip = ((f_in & mask) != 8'h00);
            endcase
         end
         2'b10: jump = 1'b1;
         default: begin
            wr_w = 1'b1;
            casez (insn[11:8])
               4'b00??: res = k8;
               4'b01??: begin res = k8; jump = 1'b1; end
               4'b1000: begin res = w_in | k8; z_upd = 1'b1; end
               4'b1001: begin res = w_in & k8; z_upd = 1'b1; end
               4'b1010: begin res = w_in ^ k8; z_upd = 1'b1; end
               4'b110?: begin
                  sum = {1'b0, k8} + {1'b0, ~w_in} + 9'h001;
                  hsum = {1'b0, k8[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01;
                  res = sum[7:0]; z_upd = 1'b1; c_upd = 1'b1; dc_upd = 1'b1;
               end
               4'b111?: begin
                  sum = {1'b0, k8} + {1'b0, w_in};
                  hsum = {1'b0, k8[3:0]} + {1'b0, w_in[3:0]};
                  res = sum[7:0]; z_upd = 1'b1; c_upd = 1'b1; dc_upd = 1'b1;
               end
               default: wr_w = 1'b0;
            endcase
            c_o = sum[8];
            dc_o = hsum[4];
         end
      endcase
      z_o = (res == 8'h00);
   end
endmodule
`default_nettype wire

// file: logic/ifd_core.sv
/*
 Instruction field decode core: takes one instruction word over
 Wishbone, runs it against an internal register file and W, keeps
 the program counter, status, direction register and upper latch.
 Assumes a classic Wishbone master on the same clock as the core.
*/
// Overview of operation
// - Each instruction is one 14-bit word split into an opcode part and operand parts.
// - Byte operations write W when the destination bit is 0 and the file register when 1.
// - The file field is a seven-bit register index from 0x00 to 0x7F.
// - Bit operations use the bit field to pick one of eight bits of the chosen register.
// - Literal and control operations take an eight-bit or eleven-bit literal.
// - Don't-care bits are ignored, with zero as the normal encoding.
// - An instruction takes one cycle, two when a test is true, the counter changes or a return form runs.
// - Each instruction cycle is four consecutive oscillator periods.
// - Writing status lets the instruction's zero, carry and digit flags override the data.
// - The direction register always reads bit 3 as one, also in read-modify-write.
// - Reading the low counter byte gives its value; writing it loads the counter from it and the upper latch.
// - The upper counter byte is not addressable as a file register and changes only by latch, flow or a Wishbone counter write.
// - Bit set and clear read the whole register, change one bit and write the byte back.
`timescale 1ns/10ps
`default_nettype none
module ifd_core
   import ifd_pkg::*;
#(
   parameter int RF_DEPTH = 128
)(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic      [7:0]  pin_direction_register,
   output logic             busy
);
   ifd_state_t  state_q;
   logic [1:0]  phase_q;
   logic [13:0] insn_q;
   logic [7:0]  w_q;
   logic [7:0]  status_q;
   logic [7:0]  pin_direction_register_q;
   logic [4:0]  pc_upper_holding_latch;
   logic [12:0] pc_q;
   logic [7:0]  rf_q [RF_DEPTH];
   logic [6:0]  rf_addr_q;
   logic [31:0] cyc_cnt_q;
   logic        ack_q;
   logic        err_q;
   logic [31:0] rdat_q;
   logic [7:0]  f_rd;
   logic [7:0]  res;
   logic        to_f;
   logic        wr_w;
   logic        z_upd;
   logic        c_upd;
   logic        dc_upd;
   logic        z_o;
   logic        c_o;
   logic        dc_o;
   logic        skip;
   logic        jump;
   logic [10:0] k11;
   logic [6:0]  faddr;
   logic        req;
   logic        hit;
   logic        exec_done;
   logic        rf_wr_bus;
   logic [7:0]  pc_low_byte;

   assign pc_low_byte = pc_q[7:0];
   assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
   assign hit = (wb_adr_i <= WB_CYC) && (wb_adr_i[1:0] == 2'b00);
   assign busy = (state_q != ST_IDLE);
   assign exec_done = (phase_q == PHASE_LAST);
   assign pin_direction_register = pin_direction_register_q | (8'h01 << PIN_DIRECTION_REGISTER_IN_BIT);
   assign rf_wr_bus = req & hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == WB_RFDATA);

   // Operand read with special register views
   always_comb begin
      case (faddr)
         A_PCL: f_rd = pc_low_byte;
         A_STATUS: f_rd = status_q;
         A_PC_UPPER_HOLDING_LATCH: f_rd = {3'b000, pc_upper_holding_latch};
         A_PIN_DIRECTION_REGISTER: f_rd = pin_direction_register_q | (8'h01 << PIN_DIRECTION_REGISTER_IN_BIT);
         default: f_rd = rf_q[faddr];
      endcase
   end

   ifd_alu u_alu (
      .insn   (insn_q),
      .w_in   (w_q),
      .f_in   (f_rd),
      .c_in   (status_q[ST_C]),
      .res    (res),
      .to_f   (to_f),
      .wr_w   (wr_w),
      .z_upd  (z_upd),
      .c_upd  (c_upd),
      .dc_upd (dc_upd),
      .z_o    (z_o),
      .c_o    (c_o),
      .dc_o   (dc_o),
      .skip   (skip),
      .jump   (jump),
      .k11    (k11),
      .faddr  (faddr)
   );

   // Sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         phase_q <= 2'h0;
      end else if (clk_en) begin
         case (state_q)
            ST_IDLE: begin
               phase_q <= 2'h0;
               if (req & wb_we_i & wb_sel_i[0] & (wb_adr_i == WB_CTRL) & wb_dat_i[CTRL_GO])
                  state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               phase_q <= phase_q + 2'h1;
               if (exec_done) begin
                  if (skip | jump | (to_f & faddr == A_PCL))
                     state_q <= ST_NOP;
                  else
                     state_q <= ST_IDLE;
               end
            end
            ST_NOP: begin
               phase_q <= phase_q + 2'h1;
               if (exec_done)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Elapsed oscillator periods of executed instructions
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         cyc_cnt_q <= 32'h0000_0000;
      else if (clk_en && state_q != ST_IDLE)
         cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
   end

   // Working accumulator
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         w_q <= W_RST;
      else if (clk_en) begin
         if (state_q == ST_EXEC && exec_done && wr_w)
            w_q <= res;
         else if (!busy && req && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_W)
            w_q <= wb_dat_i[7:0];
      end
   end

   // Status register, flags win over written data
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         status_q <= STATUS_RST;
      else if (clk_en && state_q == ST_EXEC && exec_done) begin
         if (to_f && faddr == A_STATUS) begin
            status_q <= res;
            if (z_upd)
               status_q[ST_Z] <= z_o;
            if (c_upd)
               status_q[ST_C] <= c_o;
            if (dc_upd)
               status_q[ST_DC] <= dc_o;
         end else begin
            if (z_upd)
               status_q[ST_Z] <= z_o;
            if (c_upd)
               status_q[ST_C] <= c_o;
            if (dc_upd)
               status_q[ST_DC] <= dc_o;
         end
      end
   end

   // Direction register and upper holding latch
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_direction_register_q <= PIN_DIRECTION_REGISTER_RST;
         pc_upper_holding_latch <= LATH_RST;
      end else if (clk_en && state_q == ST_EXEC && exec_done && to_f) begin
         if (faddr == A_PIN_DIRECTION_REGISTER)
            pin_direction_register_q <= res | (8'h01 << PIN_DIRECTION_REGISTER_IN_BIT);
         if (faddr == A_PC_UPPER_HOLDING_LATCH)
            pc_upper_holding_latch <= res[4:0];
      end
   end

   // Program counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         pc_q <= PC_RST;
      else if (clk_en) begin
         if (state_q == ST_EXEC && exec_done) begin
            if (to_f && faddr == A_PCL)
               pc_q <= {pc_upper_holding_latch, res};
            else if (jump && insn_q[13:12] == 2'b10)
               pc_q <= {pc_upper_holding_latch[4:3], k11};
            else if (skip)
               pc_q <= pc_q + 13'h0002;
            else if (!jump)
               pc_q <= pc_q + 13'h0001;
         end else if (!busy && req && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_PC)
            pc_q <= wb_dat_i[12:0];
      end
   end

   // Instruction and register-file address latches
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         insn_q <= 14'h0000;
         rf_addr_q <= 7'h00;
      end else if (clk_en && !busy && req && wb_we_i) begin
         if (wb_adr_i == WB_INSN && wb_sel_i[1:0] == 2'b11)
            insn_q <= wb_dat_i[13:0];
         if (wb_adr_i == WB_RFADDR && wb_sel_i[0])
            rf_addr_q <= wb_dat_i[6:0];
      end
   end

   // Data register file
   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         if (state_q == ST_EXEC && exec_done && to_f && faddr != A_PCL
             && faddr != A_STATUS && faddr != A_PIN_DIRECTION_REGISTER && faddr != A_PC_UPPER_HOLDING_LATCH)
            rf_q[faddr] <= res;
         else if (!busy && rf_wr_bus)
            rf_q[rf_addr_q] <= wb_dat_i[7:0];
      end
   end

   // Wishbone answer, one cycle after the request
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (clk_en) begin
         ack_q <= req & hit;
         err_q <= req & ~hit;
         case (wb_adr_i)
            WB_INSN: rdat_q <= {18'h00000, insn_q};
            WB_CTRL: rdat_q <= {30'h0000_0000, busy, 1'b0};
            WB_W: rdat_q <= {24'h000000, w_q};
            WB_PC: rdat_q <= {19'h00000, pc_q};
            WB_STAT: rdat_q <= {11'h000, pc_upper_holding_latch, pin_direction_register_q | 8'h08, status_q};
            WB_RFADDR: rdat_q <= {25'h0000000, rf_addr_q};
            WB_RFDATA: rdat_q <= {24'h000000, rf_q[rf_addr_q]};
            default: rdat_q <= cyc_cnt_q;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

// file: shared/ifd_pkg.sv
/*
 Shared constants for the instruction field decode core: instruction
 layout, special register addresses and reset values.
 Assumes a 14-bit instruction word and a 7-bit register index.
*/
package ifd_pkg;
   localparam int IW = 14;
   localparam int FW = 7;
   localparam int PCW = 13;
   // Field positions
   localparam int F_LSB = 0;
   localparam int D_POS = 7;
   localparam int B_LSB = 7;
   localparam int K8_LSB = 0;
   localparam int K11_LSB = 0;
   // Special register addresses (register index)
   localparam logic [6:0] A_INDF = 7'h00;
   localparam logic [6:0] A_PCL = 7'h02;
   localparam logic [6:0] A_STATUS = 7'h03;
   localparam logic [6:0] A_PC_UPPER_HOLDING_LATCH = 7'h0A;
   localparam logic [6:0] A_PIN_DIRECTION_REGISTER = 7'h06;
   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   // Direction register bit forced to one
   localparam int PIN_DIRECTION_REGISTER_IN_BIT = 3;
   // Reset values
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] PIN_DIRECTION_REGISTER_RST = 8'hFF;
   localparam logic [4:0] LATH_RST = 5'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   // Last oscillator period of an instruction cycle
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // Wishbone register map (byte addresses)
   localparam logic [7:0] WB_INSN = 8'h00;
   localparam logic [7:0] WB_CTRL = 8'h04;
   localparam logic [7:0] WB_W = 8'h08;
   localparam logic [7:0] WB_PC = 8'h0C;
   localparam logic [7:0] WB_STAT = 8'h10;
   localparam logic [7:0] WB_RFADDR = 8'h14;
   localparam logic [7:0] WB_RFDATA = 8'h18;
   localparam logic [7:0] WB_CYC = 8'h1C;
   localparam int CTRL_GO = 0;
   localparam int CTRL_BUSY = 1;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_NOP  = 3'b100
   } ifd_state_t;
endpackage

// file: sim/ifd_core_checker.sv
/*
 Checker for ifd_core: bus answers, execution length, direction bit.
 Assumes it is bound to ifd_core with clk_en held high.
*/
`timescale 1ns/10ps
`default_nettype none
module ifd_core_checker
   import ifd_pkg::*;
#(
   parameter int RF_DEPTH = 128
)(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic [7:0]  pin_direction_register,
   input wire logic        busy
);
   logic take;
   logic mapped;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clk_en;
   assign mapped = (wb_adr_i <= WB_CYC) && (wb_adr_i[1:0] == 2'h0);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Four or eight oscillator periods, then idle
   sequence s_one;
      busy [*4] ##1 !busy;
   endsequence
   sequence s_two;
      busy [*8] ##1 !busy;
   endsequence
   property p_answer;
      take |=> (wb_ack_o != wb_err_o);
   endproperty
   property p_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_cause;
      (wb_ack_o || wb_err_o) |-> $past(take);
   endproperty
   property p_err;
      take && !mapped |=> wb_err_o;
   endproperty
   property p_ok;
      take && mapped |=> wb_ack_o;
   endproperty
   property p_go;
      take && wb_we_i && wb_sel_i[0] && wb_adr_i == WB_CTRL && wb_dat_i[CTRL_GO] && !busy
         |=> busy;
   endproperty
   property p_len;
      $rose(busy) |-> (s_one or s_two);
   endproperty
   property p_dir;
      pin_direction_register[PIN_DIRECTION_REGISTER_IN_BIT];
   endproperty
   property p_stat;
      wb_ack_o && $past(take && !wb_we_i && wb_adr_i == WB_STAT)
         |-> wb_dat_o[15:8] == pin_direction_register;
   endproperty
   a_answer: assert property (p_answer) else $error("no single answer to request");
   a_pulse:  assert property (p_pulse) else $error("ack longer than one cycle");
   a_cause:  assert property (p_cause) else $error("answer without request");
   a_err:    assert property (p_err) else $error("unmapped address not refused");
   a_ok:     assert property (p_ok) else $error("mapped address not acked");
   a_go:     assert property (p_go) else $error("go did not start execution");
   a_len:    assert property (p_len) else $error("wrong execution length");
   a_dir:    assert property (p_dir) else $error("direction bit 3 low");
   a_stat:   assert property (p_stat) else $error("status read direction differs");
endmodule
`default_nettype wire

// file: sim/ifd_prog_mem.sv
/*
 Program store model that hands out instruction words by counter value.
 Assumes the bench loads a word before it fetches from that address.
*/
`timescale 1ns/10ps
`default_nettype none
module ifd_prog_mem
   import ifd_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          ld_en,
   input  wire logic [12:0]   ld_addr,
   input  wire logic [IW-1:0] ld_word,
   input  wire logic [12:0]   pc,
   output logic      [IW-1:0] word
);
   logic [IW-1:0] mem_q [0:8191];
   logic [8191:0] vld_q = '0;
   always @(posedge clk_sys) begin
      if (ld_en) begin
         mem_q[ld_addr] <= ld_word;
         vld_q[ld_addr] <= 1'b1;
      end
   end
   // Unloaded places give a pattern, never a stale word
   assign word = vld_q[pc] ? mem_q[pc] : ~{1'b0, pc};
endmodule
`default_nettype wire

// file: sim/test_instruction_field_decode.sv
/*
 Self-checking bench for ifd_core: runs instructions fetched at the core's
 counter through Wishbone and checks results read back.
 Assumes ifd_core, ifd_prog_mem and ifd_core_checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_instruction_field_decode
   import ifd_pkg::*;
;
   localparam int RF_DEPTH = 128;
   logic        clk_sys;
   logic        rst_n;
   logic        clk_en;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        err;
   logic [7:0]  dir;
   logic        busy;
   logic        ld_en;
   logic [12:0] ld_addr;
   logic [13:0] ld_word;
   logic [12:0] pc_fetch;
   logic [13:0] word;
   logic [12:0] pc_exp;
   logic [31:0] cyc_exp;
   logic [31:0] last_rd;
   logic [31:0] mon_m;
   logic [7:0]  va;
   logic [7:0]  vb;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          mismatches;
   int          n_checks;

   ifd_core #(.RF_DEPTH(RF_DEPTH)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_direction_register(dir),
      .busy(busy));
   ifd_prog_mem i_mem (
      .clk_sys(clk_sys), .ld_en(ld_en), .ld_addr(ld_addr), .ld_word(ld_word),
      .pc(pc_fetch), .word(word));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      // Unanswered reads count as mismatches
      mismatches += exp_q.size();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         complete_run();
      end
      r = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      logic e;
      exp_q.push_back(x);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0, last_rd, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      bus(1'b1, a, d, r, e);
   endtask

   task automatic probe(input logic [7:0] a);
      logic [31:0] r;
      logic        e;
      bus(1'b0, a, 32'h0, r, e);
      check({31'h0, e}, 32'h1);
   endtask

   // Fetch at the core's counter, run, wait for the end
   task automatic exec(input logic [13:0] w, input logic two, input logic [12:0] npc);
      int n;
      ld_en <= 1'b1;
      ld_addr <= pc_exp;
      ld_word <= w;
      rd(WB_PC, {19'h0, pc_exp}, 32'h1FFF);
      ld_en <= 1'b0;
      pc_fetch <= last_rd[12:0];
      @(posedge clk_sys);
      wr(WB_INSN, {18'h0, word});
      wr(WB_CTRL, 32'h1);
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 20) begin
         mismatches++;
         complete_run();
      end
      cyc_exp = cyc_exp + (two ? 32'h8 : 32'h4);
      pc_exp = npc;
   endtask

   task automatic ex1(input logic [13:0] w);
      exec(w, 1'b0, pc_exp + 13'h1);
   endtask

   // Oldest expectation against each read answer
   always @(posedge clk_sys) begin
      if (ack === 1'b1 && cyc && !we && exp_q.size() > 0) begin
         mon_m = msk_q.pop_front();
         check(rdat & mon_m, exp_q.pop_front() & mon_m);
      end
   end

   initial begin
      clk_en = 1'b1;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      ld_en = 1'b0;
      ld_addr = 13'h0;
      ld_word = 14'h0;
      pc_fetch = 13'h0;
      mismatches = 0;
      n_checks = 0;
      pc_exp = PC_RST;
      cyc_exp = 32'h0;
      va = 8'($urandom(32'h68965E2D));
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(WB_W, {24'h0, W_RST}, 32'hFF);
      rd(WB_STAT, {11'h0, LATH_RST, PIN_DIRECTION_REGISTER_RST, STATUS_RST}, 32'h1FFFFF);
      // Add to W, then to the top file index
      for (int d = 0; d < 2; d++) begin
         va = 8'($urandom);
         vb = 8'($urandom);
         wr(WB_W, {24'h0, va});
         wr(WB_RFADDR, 32'h7F);
         wr(WB_RFDATA, {24'h0, vb});
         ex1({6'h07, d[0], 7'h7F});
         rd(WB_W, {24'h0, d[0] ? va : va + vb}, 32'hFF);
         rd(WB_RFDATA, {24'h0, d[0] ? va + vb : vb}, 32'hFF);
      end
      // Set and clear each bit position
      for (int b = 0; b < 8; b++) begin
         vb = 8'($urandom);
         wr(WB_RFDATA, {24'h0, vb});
         ex1({4'h5, b[2:0], 7'h7F});
         rd(WB_RFDATA, {24'h0, vb | (8'h1 << b)}, 32'hFF);
         ex1({4'h4, b[2:0], 7'h7F});
         rd(WB_RFDATA, {24'h0, vb & ~(8'h1 << b)}, 32'hFF);
      end
      exec({4'h6, 3'h7, 7'h7F}, 1'b1, pc_exp + 13'h2);
      ex1({4'h7, 3'h7, 7'h7F});
      ex1({6'h33, 8'h18});
      rd(WB_W, 32'h18, 32'hFF);
      ex1({7'h01, A_PC_UPPER_HOLDING_LATCH});
      rd(WB_STAT, {11'h0, 5'h18, 16'h0}, 32'h1F0000);
      exec({3'h5, 11'h123}, 1'b1, {2'h3, 11'h123});
      ex1({7'h03, A_STATUS});
      rd(WB_STAT, 32'h04, 32'hFF);
      ex1({7'h03, A_PIN_DIRECTION_REGISTER});
      rd(WB_STAT, 32'h0800, 32'hFF00);
      check({24'h0, dir}, 32'h08);
      ex1({6'h08, 1'b0, A_PIN_DIRECTION_REGISTER});
      rd(WB_W, 32'h08, 32'hFF);
      ex1({6'h3E, 8'hF8});
      rd(WB_STAT, 32'h07, 32'hFF);
      exec({6'h34, 8'h5A}, 1'b1, pc_exp);
      rd(WB_W, 32'h5A, 32'hFF);
      exec(14'h0008, 1'b1, pc_exp);
      ex1({6'h30, 8'h05});
      ex1({7'h01, A_PC_UPPER_HOLDING_LATCH});
      ex1({6'h30, 8'h3C});
      exec({7'h01, A_PCL}, 1'b1, 13'h053C);
      rd(WB_PC, 32'h053C, 32'h1FFF);
      probe(8'h20);
      probe(8'h06);
      rd(WB_CYC, cyc_exp, 32'hFFFF);
      repeat (2) @(posedge clk_sys);
      complete_run();
   end
endmodule

bind ifd_core ifd_core_checker #(.RF_DEPTH(RF_DEPTH)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .pin_direction_register(pin_direction_register), .busy(busy));
`default_nettype wire
